// *** inc/afeira_pkg.sv ***
/*
 * Constants for the front-end indirect register access block.
 * Assumes an 8-bit processor port and a single clock.
 */
package afeira_pkg;

    // ------------------------------------------------------------
    // Processor-visible offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_WRITE_DATA = 8'h0a;
    localparam logic [7:0] OFS_TARGET = 8'h0b;
    localparam logic [7:0] OFS_READ_DATA = 8'h2d;
    localparam logic [7:0] OFS_CLOCK_CTRL = 8'h30;

    // ------------------------------------------------------------
    // Front-end register addresses
    // ------------------------------------------------------------
    localparam logic [6:0] AFE_LINE_ADDR = 7'h00;
    localparam logic [6:0] AFE_CONV_ADDR = 7'h01;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TGT_DIR_BIT = 7;
    localparam int CLK_EN_BIT = 0;
    localparam int LINE_RESET_BIT = 7;
    localparam int LINE_FRONT_END_POWERDOWN_BIT = 6;
    localparam int LINE_LOOP_PIN_BIT = 5;
    localparam int LINE_LOOP_FILT_BIT = 4;
    localparam int LINE_BUF_OFF_BIT = 3;
    localparam int LINE_LIGHT_BIT = 2;
    localparam int LINE_UP_BIT = 1;
    localparam int LINE_ZERO_BIT = 0;
    localparam int CONV_CAL_BIT = 7;
    localparam int CONV_CLR_BIT = 6;
    localparam int CONV_OVR_HI = 5;
    localparam int CONV_OVR_LO = 3;
    localparam int CONV_GAIN_HI = 2;
    localparam int CONV_GAIN_LO = 0;

    // ------------------------------------------------------------
    // Reset values and selector codes
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] OVR_CODE_TOP = 3'h7;
    localparam logic [2:0] OVR_CODE_FIRST = 3'h2;

    // ------------------------------------------------------------
    // Transfer sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        AFEIRA_IDLE = 2'b00,
        AFEIRA_WRITE = 2'b01,
        AFEIRA_READ = 2'b10,
        AFEIRA_WAIT = 2'b11
    } afeira_state_e;

endpackage : afeira_pkg

// *** inc/afeira_if.sv ***
/*
 * Transfer channel between the sequencer and the front-end registers.
 * Assumes both ends share one clock.
 */
`timescale 1ns/100ps
interface afeira_if;
    logic req_valid;
    logic req_write;
    logic req_index;
    logic [7:0] req_data;
    logic rsp_valid;
    logic [7:0] rsp_data;

    modport master (output req_valid, output req_write, output req_index, output req_data,
                    input rsp_valid, input rsp_data);
    modport slave (input req_valid, input req_write, input req_index, input req_data,
                   output rsp_valid, output rsp_data);
endinterface : afeira_if

// *** logic/afeira_ovr_mux.sv ***
/*
 * Overrange status selector over six integrator detects.
 * Assumes detect inputs synchronous to clk_in.
 */
`timescale 1ns/100ps
module afeira_ovr_mux (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [2:0] select_in,
    input wire logic [5:0] detect_in,
    output logic status_out
);
    logic status;
    logic next_status;
    logic [2:0] pick;

    // ------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------
    // Code to integrator map
    always_comb begin
        pick = afeira_pkg::OVR_CODE_TOP - select_in;
        if (select_in < afeira_pkg::OVR_CODE_FIRST) begin
            next_status = |detect_in;
        end else begin
            next_status = detect_in[pick];
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status <= 1'b0;
        end else begin
            status <= next_status;
        end
    end

    assign status_out = status;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    ovr_or_sel_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        select_in < 3'h2 |=> status_out == $past(|detect_in))
        else $error("overrange OR selection wrong");
    ovr_one_sel_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        select_in == 3'h2 |=> status_out == $past(detect_in[5]))
        else $error("overrange code 2 not integrator 5");

endmodule : afeira_ovr_mux

// *** logic/afeira_afe_core.sv ***
/*
 * The two front-end configuration registers and their control outputs.
 * Assumes requests arrive only from the transfer sequencer.
 */
`timescale 1ns/100ps
module afeira_afe_core (
    input wire logic clk_in,
    input wire logic resetn_in,
    afeira_if.slave xfer,
    output logic [7:0] line_out,
    output logic [7:0] conv_out,
    output logic integrator_clear_out
);
    logic [7:0] line;
    logic [7:0] conv;
    logic clear;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic [7:0] next_line;
    logic [7:0] next_conv;
    logic next_clear;
    logic next_rsp_valid;
    logic [7:0] next_rsp_data;
    logic wipe;

    // ------------------------------------------------------------
    // Register update
    // ------------------------------------------------------------
    always_comb begin
        next_line = line;
        next_conv = conv;
        wipe = xfer.req_valid && xfer.req_write && !xfer.req_index
            && xfer.req_data[afeira_pkg::LINE_RESET_BIT];
        if (xfer.req_valid && xfer.req_write) begin
            if (xfer.req_index) begin
                next_conv = xfer.req_data;
            end else begin
                next_line = xfer.req_data;
            end
        end
        if (wipe) begin
            next_line = afeira_pkg::RST_BYTE;
            next_conv = afeira_pkg::RST_BYTE;
        end
        next_clear = wipe || conv[afeira_pkg::CONV_CLR_BIT];
        next_rsp_valid = xfer.req_valid && !xfer.req_write;
        next_rsp_data = xfer.req_index ? conv : line;
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            line <= afeira_pkg::RST_BYTE;
            conv <= afeira_pkg::RST_BYTE;
            clear <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= afeira_pkg::RST_BYTE;
        end else begin
            line <= next_line;
            conv <= next_conv;
            clear <= next_clear;
            rsp_valid <= next_rsp_valid;
            rsp_data <= next_rsp_data;
        end
    end

    assign line_out = line;
    assign conv_out = conv;
    assign integrator_clear_out = clear;
    assign xfer.rsp_valid = rsp_valid;
    assign xfer.rsp_data = rsp_data;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence line_reset_s;
        xfer.req_valid && xfer.req_write && !xfer.req_index && xfer.req_data[7];
    endsequence

    reset_all_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        line_reset_s |=> line == 8'h00 && conv == 8'h00 && integrator_clear_out)
        else $error("front-end reset did not clear registers");
    conv_store_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        xfer.req_valid && xfer.req_write && xfer.req_index |=> conv == $past(xfer.req_data))
        else $error("converter register not written");
    fetch_answer_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        xfer.req_valid && !xfer.req_write && !xfer.req_index |=> rsp_valid && rsp_data == $past(line))
        else $error("fetch answer wrong");

endmodule : afeira_afe_core

// *** logic/afeira_top.sv ***
/*
 * Indirect access path from processor registers to two front-end registers.
 * Assumes single-cycle processor strobes synchronous to clk_in.
 */
`timescale 1ns/100ps
module afeira_top (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic cpu_cs_in,
    input wire logic cpu_we_in,
    input wire logic cpu_re_in,
    input wire logic [7:0] cpu_addr_in,
    input wire logic [7:0] cpu_wdata_in,
    input wire logic [5:0] integrator_overrange_in,
    output logic [7:0] cpu_rdata_out,
    output logic cpu_rvalid_out,
    output logic master_clock_enable_out,
    output logic front_end_powerdown_out,
    output logic line_pin_loopback_out,
    output logic filter_output_loopback_out,
    output logic tx_buffer_off_out,
    output logic tx_light_load_mode_out,
    output logic upstream_select_out,
    output logic normal_mode_zero_bit_out,
    output logic rx_offset_calibrate_out,
    output logic rx_integrator_clear_out,
    output logic [2:0] rx_gain_select_out,
    output logic overrange_status_out
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    afeira_if xfer ();

    logic [7:0] afe_write_data;
    logic [7:0] afe_target_and_direction;
    logic [7:0] afe_read_data;
    logic [7:0] master_clock_control;
    logic [7:0] next_afe_write_data;
    logic [7:0] next_afe_target_and_direction;
    logic [7:0] next_afe_read_data;
    logic [7:0] next_master_clock_control;

    afeira_pkg::afeira_state_e state;
    afeira_pkg::afeira_state_e next_state;
    logic req_valid;
    logic req_write;
    logic req_index;
    logic [7:0] req_data;
    logic next_req_valid;
    logic next_req_write;
    logic next_req_index;
    logic [7:0] next_req_data;

    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] next_rdata;
    logic next_rvalid;

    logic [7:0] line;
    logic [7:0] conv;
    logic clock_on;
    logic wr_hit;
    logic rd_hit;
    logic open_access;
    logic tgt_write;
    logic tgt_known;

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    assign clock_on = master_clock_control[afeira_pkg::CLK_EN_BIT];
    assign open_access = clock_on || (cpu_addr_in == afeira_pkg::OFS_CLOCK_CTRL);
    assign wr_hit = cpu_cs_in && cpu_we_in && open_access;
    assign rd_hit = cpu_cs_in && cpu_re_in && !cpu_we_in;
    // Only the target register starts a transfer
    assign tgt_write = wr_hit && (cpu_addr_in == afeira_pkg::OFS_TARGET);
    assign tgt_known = cpu_wdata_in[6:0] == afeira_pkg::AFE_LINE_ADDR
        || cpu_wdata_in[6:0] == afeira_pkg::AFE_CONV_ADDR;

    // ------------------------------------------------------------
    // Processor registers
    // ------------------------------------------------------------
    always_comb begin
        next_afe_write_data = afe_write_data;
        next_afe_target_and_direction = afe_target_and_direction;
        next_afe_read_data = afe_read_data;
        next_master_clock_control = master_clock_control;
        if (wr_hit) begin
            case (cpu_addr_in)
                afeira_pkg::OFS_WRITE_DATA: begin
                    next_afe_write_data = cpu_wdata_in;
                end
                afeira_pkg::OFS_TARGET: begin
                    next_afe_target_and_direction = cpu_wdata_in;
                end
                afeira_pkg::OFS_READ_DATA: begin
                    next_afe_read_data = cpu_wdata_in;
                end
                afeira_pkg::OFS_CLOCK_CTRL: begin
                    next_master_clock_control = cpu_wdata_in;
                end
                default: begin
                    next_afe_write_data = afe_write_data;
                end
            endcase
        end
        if (state == afeira_pkg::AFEIRA_WAIT && xfer.rsp_valid) begin
            next_afe_read_data = xfer.rsp_data;
        end else if (tgt_write && cpu_wdata_in[afeira_pkg::TGT_DIR_BIT] && !tgt_known) begin
            next_afe_read_data = afeira_pkg::RST_BYTE;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            afe_write_data <= afeira_pkg::RST_BYTE;
            afe_target_and_direction <= afeira_pkg::RST_BYTE;
            afe_read_data <= afeira_pkg::RST_BYTE;
            master_clock_control <= afeira_pkg::RST_BYTE;
        end else begin
            afe_write_data <= next_afe_write_data;
            afe_target_and_direction <= next_afe_target_and_direction;
            afe_read_data <= next_afe_read_data;
            master_clock_control <= next_master_clock_control;
        end
    end

    // ------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_req_valid = 1'b0;
        next_req_write = req_write;
        next_req_index = req_index;
        next_req_data = req_data;
        case (state)
            afeira_pkg::AFEIRA_IDLE: begin
                if (tgt_write && tgt_known) begin
                    next_req_valid = 1'b1;
                    next_req_index = cpu_wdata_in[0];
                    if (cpu_wdata_in[afeira_pkg::TGT_DIR_BIT]) begin
                        next_req_write = 1'b0;
                        next_state = afeira_pkg::AFEIRA_READ;
                    end else begin
                        next_req_write = 1'b1;
                        next_req_data = afe_write_data;
                        next_state = afeira_pkg::AFEIRA_WRITE;
                    end
                end
            end
            afeira_pkg::AFEIRA_WRITE: begin
                next_state = afeira_pkg::AFEIRA_IDLE;
            end
            afeira_pkg::AFEIRA_READ: begin
                next_state = afeira_pkg::AFEIRA_WAIT;
            end
            afeira_pkg::AFEIRA_WAIT: begin
                if (xfer.rsp_valid) begin
                    next_state = afeira_pkg::AFEIRA_IDLE;
                end
            end
            default: begin
                next_state = afeira_pkg::AFEIRA_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= afeira_pkg::AFEIRA_IDLE;
            req_valid <= 1'b0;
            req_write <= 1'b0;
            req_index <= 1'b0;
            req_data <= afeira_pkg::RST_BYTE;
        end else begin
            state <= next_state;
            req_valid <= next_req_valid;
            req_write <= next_req_write;
            req_index <= next_req_index;
            req_data <= next_req_data;
        end
    end

    assign xfer.req_valid = req_valid;
    assign xfer.req_write = req_write;
    assign xfer.req_index = req_index;
    assign xfer.req_data = req_data;

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_comb begin
        next_rvalid = rd_hit;
        next_rdata = afeira_pkg::RST_BYTE;
        if (rd_hit && open_access) begin
            case (cpu_addr_in)
                afeira_pkg::OFS_WRITE_DATA: begin
                    next_rdata = afe_write_data;
                end
                afeira_pkg::OFS_TARGET: begin
                    next_rdata = afe_target_and_direction;
                end
                afeira_pkg::OFS_READ_DATA: begin
                    next_rdata = afe_read_data;
                end
                afeira_pkg::OFS_CLOCK_CTRL: begin
                    next_rdata = master_clock_control;
                end
                default: begin
                    next_rdata = afeira_pkg::RST_BYTE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata <= afeira_pkg::RST_BYTE;
            rvalid <= 1'b0;
        end else begin
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    assign cpu_rdata_out = rdata;
    assign cpu_rvalid_out = rvalid;
    assign master_clock_enable_out = clock_on;

    // ------------------------------------------------------------
    // Front end and its control outputs
    // ------------------------------------------------------------
    afeira_afe_core u_core (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .xfer(xfer.slave),
        .line_out(line),
        .conv_out(conv),
        .integrator_clear_out(rx_integrator_clear_out)
    );

    assign front_end_powerdown_out = line[afeira_pkg::LINE_FRONT_END_POWERDOWN_BIT];
    assign line_pin_loopback_out = line[afeira_pkg::LINE_LOOP_PIN_BIT];
    assign filter_output_loopback_out = line[afeira_pkg::LINE_LOOP_FILT_BIT];
    assign tx_buffer_off_out = line[afeira_pkg::LINE_BUF_OFF_BIT];
    assign tx_light_load_mode_out = line[afeira_pkg::LINE_LIGHT_BIT];
    assign upstream_select_out = line[afeira_pkg::LINE_UP_BIT];
    assign normal_mode_zero_bit_out = line[afeira_pkg::LINE_ZERO_BIT];
    assign rx_offset_calibrate_out = conv[afeira_pkg::CONV_CAL_BIT];
    assign rx_gain_select_out = conv[afeira_pkg::CONV_GAIN_HI:afeira_pkg::CONV_GAIN_LO];

    afeira_ovr_mux u_ovr (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .select_in(conv[afeira_pkg::CONV_OVR_HI:afeira_pkg::CONV_OVR_LO]),
        .detect_in(integrator_overrange_in),
        .status_out(overrange_status_out)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking chk_cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    sequence idle_copy_s;
        state == afeira_pkg::AFEIRA_IDLE && tgt_write && tgt_known && !cpu_wdata_in[7];
    endsequence

    sequence idle_fetch_s;
        state == afeira_pkg::AFEIRA_IDLE && tgt_write && cpu_wdata_in[6:0] == 7'h00 && cpu_wdata_in[7];
    endsequence

    gate_closed_a: assert property (
        cpu_cs_in && cpu_we_in && !clock_on && cpu_addr_in != 8'h30 |=> $stable(afe_write_data))
        else $error("write accepted while clock disabled");
    copy_issue_a: assert property (
        idle_copy_s |=> req_valid && req_write && req_data == $past(afe_write_data))
        else $error("copy transfer not issued");
    fetch_fill_a: assert property (
        idle_fetch_s |-> ##3 afe_read_data == $past(line, 2))
        else $error("fetched value not placed in read-data");
    only_path_a: assert property (
        req_valid |-> $past(tgt_write))
        else $error("transfer without target write");
    read_hold_a: assert property (
        state == afeira_pkg::AFEIRA_IDLE && !(wr_hit && cpu_addr_in == 8'h2d) && !tgt_write
        |=> $stable(afe_read_data))
        else $error("read-data changed without a fetch");
    front_end_powerdown_follow_a: assert property (
        (idle_copy_s and (cpu_wdata_in[0] == 1'b0)) ##1 (req_valid && !req_data[7])
        |=> front_end_powerdown_out == $past(req_data[6]))
        else $error("power-down bit not applied");

endmodule : afeira_top

// *** tb/afeira_cpu_model.sv ***
/* Processor model on the 8-bit register port, with indirect transfer helpers.
   Assumes the bench clock; all signals change on the falling edge. */
`timescale 1ns/100ps
module afeira_cpu_model #(
    parameter int SYM_CYCLES = 4
) (
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    input wire logic rvalid_in,
    output logic cs_out,
    output logic we_out,
    output logic re_out,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out
);
    initial begin
        {cs_out, we_out, re_out, addr_out, wdata_out} = 19'h00000;
    end
    // Released lines show inverted values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        {cs_out, we_out, re_out, addr_out, wdata_out} = {3'b110, a, d};
        @(negedge clk_in);
        {cs_out, we_out, addr_out, wdata_out} = {2'b00, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_in);
        {cs_out, we_out, re_out, addr_out} = {3'b101, a};
        @(negedge clk_in);
        {cs_out, re_out, addr_out} = {2'b00, ~a};
        d = rvalid_in ? rdata_in : 8'hxx;
    endtask : rd
    task automatic afe_wr(input logic [6:0] idx, input logic [7:0] d);
        wr(8'h0b, {1'b1, idx});
        repeat (3 * SYM_CYCLES) @(negedge clk_in);
        wr(8'h0a, (idx == 7'h00) ? (d & 8'hfe) : d);
        wr(8'h0b, {1'b0, idx});
        repeat (2 * SYM_CYCLES) @(negedge clk_in);
    endtask : afe_wr
    task automatic afe_rd(input logic [6:0] idx, output logic [7:0] d);
        wr(8'h0b, {1'b1, idx});
        repeat (3 * SYM_CYCLES) @(negedge clk_in);
        rd(8'h2d, d);
    endtask : afe_rd
endmodule : afeira_cpu_model

// *** tb/tb.sv ***
/* Self-checking bench for the front-end indirect access block.
   Assumes the processor model drives the register port. */
`timescale 1ns/100ps
module tb;
    logic clk_in, resetn_in, cs, we, re, rv, clk_en, pd, pin, filt, off, light, up, zero, cal, iclr, ovr;
    logic [7:0] addr, wdata, rdata, got;
    logic [2:0] gain;
    logic [5:0] detect;
    int bad_count, n_checks;
    int clr_cycles;
    always @(posedge clk_in) begin
        if (iclr === 1'b1) begin
            clr_cycles <= clr_cycles + 1;
        end
    end
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    afeira_cpu_model u_cpu (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rv), .cs_out(cs),
        .we_out(we), .re_out(re), .addr_out(addr), .wdata_out(wdata));
    afeira_top u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .cpu_cs_in(cs), .cpu_we_in(we),
        .cpu_re_in(re), .cpu_addr_in(addr), .cpu_wdata_in(wdata), .integrator_overrange_in(detect),
        .cpu_rdata_out(rdata), .cpu_rvalid_out(rv), .master_clock_enable_out(clk_en),
        .front_end_powerdown_out(pd), .line_pin_loopback_out(pin), .filter_output_loopback_out(filt),
        .tx_buffer_off_out(off), .tx_light_load_mode_out(light), .upstream_select_out(up),
        .normal_mode_zero_bit_out(zero), .rx_offset_calibrate_out(cal), .rx_integrator_clear_out(iclr),
        .rx_gain_select_out(gain), .overrange_status_out(ovr));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic t_gate;
        chk("outputs at reset", 8'h00, {pd, pin, filt, off, light, up, zero, cal});
        u_cpu.wr(8'h0a, 8'h5a);
        u_cpu.rd(8'h0a, got);
        chk("gated read", 8'h00, got);
        u_cpu.rd(8'h30, got);
        chk("clock control", 8'h00, got);
        u_cpu.wr(8'h30, 8'h01);
        u_cpu.rd(8'h0a, got);
        chk("gated write", 8'h00, got);
        chk("clock enable", 8'h01, {7'h00, clk_en});
        $display("t_gate done");
    endtask : t_gate
    task automatic t_line;
        u_cpu.rd(8'h00, got);
        chk("direct offset", 8'h00, got);
        u_cpu.afe_wr(7'h00, 8'h56);
        chk("line outputs", 8'h56, {1'b0, pd, pin, filt, off, light, up, zero});
        u_cpu.afe_wr(7'h00, 8'h2a);
        chk("line outputs", 8'h2a, {1'b0, pd, pin, filt, off, light, up, zero});
        u_cpu.afe_rd(7'h00, got);
        chk("line fetch", 8'h2a, got);
        $display("t_line done");
    endtask : t_line
    task automatic t_conv;
        u_cpu.afe_wr(7'h01, 8'hbd);
        chk("converter outputs", 8'h0d, {4'h0, cal, gain});
        u_cpu.afe_rd(7'h01, got);
        chk("converter fetch", 8'hbd, got);
        u_cpu.wr(8'h0a, 8'h00);
        u_cpu.rd(8'h2d, got);
        chk("read data hold", 8'hbd, got);
        u_cpu.wr(8'h0b, 8'h85);
        u_cpu.rd(8'h2d, got);
        chk("unknown target fetch", 8'h00, got);
        for (int c = 0; c < 8; c++) begin
            detect = (c < 2) ? 6'h04 : 6'h3f ^ (6'h01 << (7 - c));
            u_cpu.afe_wr(7'h01, {2'b00, c[2:0], 3'b000});
            chk("overrange", (c < 2) ? 8'h01 : 8'h00, {7'h00, ovr});
        end
        $display("t_conv done");
    endtask : t_conv
    task automatic t_clear;
        int n0;
        u_cpu.afe_wr(7'h01, 8'h07);
        n0 = clr_cycles;
        u_cpu.afe_wr(7'h00, 8'h80);
        chk("gain cleared", 8'h00, {5'h00, gain});
        chk("integrator clear cycles", 8'h01, 8'(clr_cycles - n0));
        u_cpu.afe_rd(7'h00, got);
        chk("line cleared", 8'h00, got);
        $display("t_clear done");
    endtask : t_clear
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out
    initial begin
        resetn_in = 1'b0;
        detect = 6'h00;
        bad_count = 0;
        n_checks = 0;
        repeat (3) @(negedge clk_in);
        resetn_in = 1'b1;
        t_gate();
        t_line();
        t_conv();
        t_clear();
        close_out();
    end
    initial begin
        #100000;
        bad_count++;
        close_out();
    end
endmodule : tb
